// File: core/sfpe_pkg.sv
/* Shared constants and types of the serial flash command sequencer:
   opcodes, frame byte counts, protection geometry, self-timed durations.
   Assumes a 250 MHz core clock and a 4 MiB array behind a byte port. */
package sfpe_pkg;
  localparam longint unsigned CLK_MHZ = 250;
  localparam int ADDR_W = 22;
  localparam int PAGE_BYTES = 256;

  // Opcodes
  localparam logic [7:0] OPC_WREN = 8'h06;
  localparam logic [7:0] OPC_WRDI = 8'h04;
  localparam logic [7:0] OPC_RDSR = 8'h05;
  localparam logic [7:0] OPC_DREAD = 8'h3B;
  localparam logic [7:0] OPC_PAGE = 8'h02;
  localparam logic [7:0] OPC_SECT = 8'h20;
  localparam logic [7:0] OPC_BLK = 8'hD8;
  localparam logic [7:0] OPC_CHIP = 8'hC7;
  localparam logic [7:0] OPC_SLEEP = 8'hB9;
  localparam logic [7:0] OPC_WAKE = 8'hAB;

  // Byte counts that make a deselect valid; BYTES_HDR instead ends the address phase
  localparam logic [2:0] BYTES_CMD = 3'h1;
  localparam logic [2:0] BYTES_HDR = 3'h3;
  localparam logic [2:0] BYTES_ERASE = 3'h4;
  localparam logic [2:0] BYTES_PAGE = 3'h5;

  // Protection: 64 blocks of 64 KiB
  localparam logic [6:0] BLOCKS_ALL = 7'h40;
  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_ALL = 3'h7;

  // Self-timed durations, as printed, and their cycle counts
  localparam longint unsigned PAGE_WRITE_TIME_US = 1500;
  localparam longint unsigned SECTOR_ERASE_TIME_MS = 150;
  localparam longint unsigned BLOCK_ERASE_TIME_MS = 800;
  localparam longint unsigned ARRAY_ERASE_TIME_S = 25;
  localparam longint unsigned POWERDOWN_ENTRY_TIME_US = 3;
  localparam longint unsigned PAGE_WRITE_CYC = PAGE_WRITE_TIME_US * CLK_MHZ;
  localparam longint unsigned SECTOR_ERASE_CYC =
    SECTOR_ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam longint unsigned BLOCK_ERASE_CYC =
    BLOCK_ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam longint unsigned ARRAY_ERASE_CYC =
    ARRAY_ERASE_TIME_S * 1000000 * CLK_MHZ;
  localparam longint unsigned POWERDOWN_ENTRY_CYC =
    POWERDOWN_ENTRY_TIME_US * CLK_MHZ;
  localparam int TIMER_W = 33;

  typedef enum logic [2:0] {
    PH_OPC = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b010,
    PH_PAGE = 3'b011,
    PH_READ = 3'b100,
    PH_STAT = 3'b101,
    PH_SKIP = 3'b110
  } sfpe_phase_e;

  typedef enum logic [1:0] {
    EX_IDLE = 2'b00,
    EX_PROG = 2'b01,
    EX_WAIT = 2'b10,
    EX_SLEEP = 2'b11
  } sfpe_exec_e;

  typedef enum logic [1:0] {
    ER_SECTOR = 2'b00,
    ER_BLOCK = 2'b01,
    ER_CHIP = 2'b10
  } sfpe_erase_e;

  typedef struct packed {
    logic wr;
    logic erase;
    sfpe_erase_e kind;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } sfpe_mem_s;
endpackage

// File: core/sfpe_page_buf.sv
/* Page staging buffer: 256 bytes with a written-mask.
   Assumes one writer and one reader on the core clock; clr and wrEn
   never coincide with a read that matters. */
`timescale 1ns/10ps
module sfpe_page_buf
  import sfpe_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Fill side
  input wire logic clr,
  input wire logic wrEn,
  input wire logic [7:0] wrIdx,
  input wire logic [7:0] wrData,
  // Drain side
  input wire logic [7:0] rdIdx,
  output logic [7:0] rdData,
  output logic rdValid
);
  logic [7:0] memQ [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] validQ;

  // Only the mask needs a reset; stale bytes are never marked valid
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      validQ <= '0;
    end else if (ce) begin
      if (clr) begin
        validQ <= '0;
      end else if (wrEn) begin
        validQ[wrIdx] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && wrEn) begin
      memQ[wrIdx] <= wrData;
    end
  end

  assign rdData = memQ[rdIdx];
  assign rdValid = validQ[rdIdx];
endmodule

// File: core/sfpe_core.sv
/* Serial flash command sequencer: decodes link frames, streams dual
   reads, stages page data, runs self-timed program/erase and sleep.
   Assumes link pins are asynchronous and the link clock is well below
   a sixth of ref_clk; the array port answers reads within one cycle. */
`timescale 1ns/10ps
module sfpe_core
  import sfpe_pkg::*;
#(
  parameter longint unsigned P_PAGE_WRITE_CYC = PAGE_WRITE_CYC,
  parameter longint unsigned P_SECTOR_ERASE_CYC = SECTOR_ERASE_CYC,
  parameter longint unsigned P_BLOCK_ERASE_CYC = BLOCK_ERASE_CYC,
  parameter longint unsigned P_ARRAY_ERASE_CYC = ARRAY_ERASE_CYC,
  parameter longint unsigned P_POWERDOWN_ENTRY_CYC = POWERDOWN_ENTRY_CYC
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Link pins
  input wire logic sclk,
  input wire logic csN,
  input wire logic bidirDataPinIn,
  output logic bidirDataPinOut,
  output logic bidirDataPinOe,
  output logic dataOut,
  output logic dataOutOe,
  // Protection setup
  input wire logic topBottomSelect,
  input wire logic [2:0] protectBits,
  // Status view
  output logic busy,
  output logic writeEnableLatch,
  output logic poweredDown,
  // Array port
  output sfpe_mem_s memReq,
  output logic [ADDR_W-1:0] memRdAddr,
  input wire logic [7:0] memRdData
);
  logic [2:0] s1Q, s2Q, s3Q;
  sfpe_phase_e phaseQ, phaseNext;
  sfpe_exec_e execQ;
  logic [2:0] bitQ, byteQ, outCntQ;
  logic [6:0] shQ;
  logic [7:0] opcQ, walkQ;
  logic [23:0] addrQ;
  logic [13:0] pageQ;
  logic okQ, welQ, pdQ, doQ, dioQ, doOeQ, dioOeQ;
  logic [TIMER_W-1:0] timerQ;
  logic [7:0] bufData;
  logic bufValid;

  // Two flops per link input, third stage only for edge finding
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle levels, so no false select edge follows reset
      s1Q <= 3'h7;
      s2Q <= 3'h7;
      s3Q <= 3'h7;
    end else if (ce) begin
      s1Q <= {csN, sclk, bidirDataPinIn};
      s2Q <= s1Q;
      s3Q <= s2Q;
    end
  end

  wire logic csAct = !s2Q[2];
  wire logic csRise = s2Q[2] && !s3Q[2];
  wire logic sclkRise = csAct && s2Q[1] && !s3Q[1];
  wire logic sclkFall = csAct && !s2Q[1] && s3Q[1];
  wire logic din = s2Q[0];
  wire logic [7:0] opcIn = {shQ, din};
  wire logic byteDone = sclkRise && (bitQ == 3'h7);
  wire logic busyW = (execQ == EX_PROG) || (execQ == EX_WAIT);
  wire logic asleep = pdQ || (execQ == EX_SLEEP);
  wire logic outPhase = (phaseQ == PH_READ) || (phaseQ == PH_STAT);

  // While asleep only wake counts; while busy only status read
  wire logic opcOk = asleep ? (opcIn == OPC_WAKE) :
    busyW ? (opcIn == OPC_RDSR) : 1'b1;
  wire logic needsWel = (opcIn == OPC_PAGE) || (opcIn == OPC_SECT) ||
    (opcIn == OPC_BLK) || (opcIn == OPC_CHIP);
  wire logic opcAccept = opcOk && !(needsWel && !welQ);

  // Protected span in blocks, counted from top or bottom
  wire logic [6:0] protLen = (protectBits == BP_NONE) ? 7'h00 :
    (protectBits == BP_ALL) ? BLOCKS_ALL :
    7'(7'h01 << (protectBits - 3'h1));
  wire logic [6:0] blkIdx = {1'b0, addrQ[21:16]};
  wire logic protHit = topBottomSelect ? (blkIdx < protLen) :
    (blkIdx >= 7'(BLOCKS_ALL - protLen));

  // Commands act only when select rises on a byte boundary
  wire logic cmdEnd = csRise && okQ && (bitQ == 3'h0);
  wire logic isErase = (opcQ == OPC_SECT) || (opcQ == OPC_BLK);
  wire logic startProg = cmdEnd && (opcQ == OPC_PAGE) &&
    (byteQ >= BYTES_PAGE) && !protHit;
  wire logic startErase = cmdEnd && isErase &&
    (byteQ == BYTES_ERASE) && !protHit;
  wire logic startChip = cmdEnd && (opcQ == OPC_CHIP) &&
    (byteQ == BYTES_CMD) && (protectBits == BP_NONE);
  wire logic startSleep = cmdEnd && (opcQ == OPC_SLEEP) &&
    (byteQ == BYTES_CMD);
  wire logic doWren = cmdEnd && (opcQ == OPC_WREN) && (byteQ == BYTES_CMD);
  wire logic doWrdi = cmdEnd && (opcQ == OPC_WRDI) && (byteQ == BYTES_CMD);
  wire logic doWake = cmdEnd && (opcQ == OPC_WAKE) && asleep &&
    (byteQ != 3'h0);

  wire logic [7:0] statusByte = {2'b00, topBottomSelect, protectBits,
    welQ, busyW};
  wire logic bufClr = byteDone && (phaseQ == PH_OPC) &&
    (opcIn == OPC_PAGE) && opcAccept;
  wire logic bufWr = byteDone && (phaseQ == PH_PAGE);

  // Frame phase after the byte now completing
  always_comb begin
    phaseNext = phaseQ;
    case (phaseQ)
      PH_OPC: begin
        if (!opcAccept) begin
          phaseNext = PH_SKIP;
        end else if (opcIn == OPC_RDSR) begin
          phaseNext = PH_STAT;
        end else if (opcIn == OPC_DREAD || opcIn == OPC_PAGE ||
            opcIn == OPC_SECT || opcIn == OPC_BLK) begin
          phaseNext = PH_ADDR;
        end else begin
          phaseNext = PH_SKIP;
        end
      end
      PH_ADDR: begin
        if (byteQ == BYTES_HDR) begin
          phaseNext = (opcQ == OPC_DREAD) ? PH_DUMMY :
            (opcQ == OPC_PAGE) ? PH_PAGE : PH_SKIP;
        end
      end
      PH_DUMMY: phaseNext = PH_READ;
      default: phaseNext = phaseQ;
    endcase
  end

  // Frame decode on link clock edges; deselect aborts the frame
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseQ <= PH_OPC;
      bitQ <= 3'h0;
      byteQ <= 3'h0;
      outCntQ <= 3'h0;
      shQ <= 7'h00;
      opcQ <= 8'h00;
      addrQ <= 24'h000000;
      okQ <= 1'b0;
    end else if (ce) begin
      if (!csAct) begin
        phaseQ <= PH_OPC;
        bitQ <= 3'h0;
        byteQ <= 3'h0;
        outCntQ <= 3'h0;
      end else if (sclkRise) begin
        shQ <= opcIn[6:0];
        bitQ <= bitQ + 3'h1;
        if (phaseQ == PH_ADDR) begin
          addrQ <= {addrQ[22:0], din};
        end
        if (byteDone) begin
          phaseQ <= phaseNext;
          if (byteQ != 3'h7) begin
            byteQ <= byteQ + 3'h1;
          end
          if (!outPhase) begin
            outCntQ <= 3'h0;
          end
          if (phaseQ == PH_OPC) begin
            opcQ <= opcIn;
            okQ <= opcAccept;
          end
          if (phaseQ == PH_PAGE) begin
            addrQ[7:0] <= addrQ[7:0] + 8'h01;
          end
        end
      end else if (sclkFall && outPhase) begin
        outCntQ <= outCntQ + 3'h1;
        if (phaseQ == PH_READ && outCntQ[1:0] == 2'h3) begin
          addrQ <= addrQ + 24'h000001;
        end
      end
    end
  end

  // Pins change on falling link edges; deselect only drops the enables
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      doQ <= 1'b0;
      dioQ <= 1'b0;
      doOeQ <= 1'b0;
      dioOeQ <= 1'b0;
    end else if (ce) begin
      if (!csAct) begin
        doOeQ <= 1'b0;
        dioOeQ <= 1'b0;
      end else if (sclkFall && phaseQ == PH_STAT) begin
        doOeQ <= 1'b1;
        doQ <= statusByte[~outCntQ];
      end else if (sclkFall && phaseQ == PH_READ) begin
        // Bidir pin is driven only from the first data fall
        doOeQ <= 1'b1;
        dioOeQ <= 1'b1;
        doQ <= memRdData[{~outCntQ[1:0], 1'b1}];
        dioQ <= memRdData[{~outCntQ[1:0], 1'b0}];
      end
    end
  end

  sfpe_page_buf u_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .clr(bufClr),
    .wrEn(bufWr),
    .wrIdx(addrQ[7:0]),
    .wrData(opcIn),
    .rdIdx(walkQ),
    .rdData(bufData),
    .rdValid(bufValid)
  );

  // Self-timed cycles; timer counts cover the slow array, walk is 256
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      execQ <= EX_IDLE;
      timerQ <= '0;
      walkQ <= 8'h00;
      pageQ <= 14'h0000;
      welQ <= 1'b0;
      pdQ <= 1'b0;
      memReq <= '0;
    end else if (ce) begin
      memReq.wr <= 1'b0;
      memReq.erase <= 1'b0;
      if (timerQ != '0) begin
        timerQ <= timerQ - 33'h1;
      end
      case (execQ)
        EX_IDLE: begin
          if (doWren) begin
            welQ <= 1'b1;
          end else if (doWrdi) begin
            welQ <= 1'b0;
          end
          if (doWake) begin
            pdQ <= 1'b0;
          end
          if (startProg) begin
            execQ <= EX_PROG;
            walkQ <= 8'h00;
            pageQ <= addrQ[21:8];
            timerQ <= TIMER_W'(P_PAGE_WRITE_CYC);
          end else if (startErase || startChip) begin
            execQ <= EX_WAIT;
            memReq.erase <= 1'b1;
            memReq.addr <= addrQ[ADDR_W-1:0];
            memReq.kind <= startChip ? ER_CHIP :
              (opcQ == OPC_SECT) ? ER_SECTOR : ER_BLOCK;
            timerQ <= startChip ? TIMER_W'(P_ARRAY_ERASE_CYC) :
              (opcQ == OPC_SECT) ? TIMER_W'(P_SECTOR_ERASE_CYC) :
              TIMER_W'(P_BLOCK_ERASE_CYC);
          end else if (startSleep) begin
            execQ <= EX_SLEEP;
            timerQ <= TIMER_W'(P_POWERDOWN_ENTRY_CYC);
          end
        end
        EX_PROG: begin
          // Only bytes received this command are written
          memReq.wr <= bufValid;
          memReq.addr <= {pageQ, walkQ};
          memReq.data <= bufData;
          walkQ <= walkQ + 8'h01;
          if (walkQ == 8'hFF) begin
            execQ <= EX_WAIT;
          end
        end
        EX_WAIT: begin
          if (timerQ == '0) begin
            execQ <= EX_IDLE;
            welQ <= 1'b0;
          end
        end
        EX_SLEEP: begin
          if (doWake) begin
            execQ <= EX_IDLE;
          end else if (timerQ == '0) begin
            execQ <= EX_IDLE;
            pdQ <= 1'b1;
          end
        end
        default: execQ <= EX_IDLE;
      endcase
    end
  end

  assign bidirDataPinOut = dioQ;
  assign bidirDataPinOe = dioOeQ;
  assign dataOut = doQ;
  assign dataOutOe = doOeQ;
  assign busy = busyW;
  assign writeEnableLatch = welQ;
  assign poweredDown = pdQ;
  assign memRdAddr = addrQ[ADDR_W-1:0];

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_wel_cleared;
    $fell(busyW) |-> !welQ;
  endproperty
  a_wel_cleared: assert property (p_wel_cleared)
    else $error("latch still set after cycle end");

  property p_asleep_quiet;
    pdQ |-> !doOeQ && !dioOeQ && !busyW;
  endproperty
  a_asleep_quiet: assert property (p_asleep_quiet)
    else $error("pins or busy active while asleep");

  property p_prog_unprotected;
    startProg |-> !protHit ##1 (execQ == EX_PROG);
  endproperty
  a_prog_unprotected: assert property (p_prog_unprotected)
    else $error("program started on protected page");

  property p_busy_holds;
    (ce && startProg) |=> busyW [*8];
  endproperty
  a_busy_holds: assert property (p_busy_holds)
    else $error("busy dropped during page write");

  property p_chip_guard;
    startChip |-> protectBits == BP_NONE && welQ;
  endproperty
  a_chip_guard: assert property (p_chip_guard)
    else $error("chip erase despite protection or latch");

  property p_wel_needed;
    (startProg || startErase) |-> welQ;
  endproperty
  a_wel_needed: assert property (p_wel_needed)
    else $error("program or erase without latch");

  property p_dual_pair;
    (ce && sclkFall && phaseQ == PH_READ && outCntQ[1:0] == 2'h0) |=>
      doQ == $past(memRdData[7]) && dioQ == $past(memRdData[6]);
  endproperty
  a_dual_pair: assert property (p_dual_pair)
    else $error("dual read bit order wrong");

  property p_whole_byte;
    (startProg || startErase || startChip || startSleep) |->
      csRise && bitQ == 3'h0;
  endproperty
  a_whole_byte: assert property (p_whole_byte)
    else $error("command ran on partial byte");

  property p_idle_start;
    (startProg || startErase || startChip) |-> execQ == EX_IDLE;
  endproperty
  a_idle_start: assert property (p_idle_start)
    else $error("command started while busy");

  property p_page_wrap;
    memReq.wr |-> memReq.addr[ADDR_W-1:8] == pageQ;
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("page write left its page");

  c_dual_read: cover property (sclkFall && phaseQ == PH_READ);
  c_page_prog: cover property (execQ == EX_PROG && memReq.wr);
  c_sleep: cover property ($rose(pdQ));
  c_erase: cover property (startErase);
endmodule

// File: dv/sfpe_host_model.sv
/* SPI host model for the flash sequencer: mode 0 frames, MSB first.
   Assumes the bench forms the shared data line and watches rxEv. */
`timescale 1ns/10ps
module sfpe_host_model (
  // Clock
  input wire logic ref_clk,
  // Link drive
  output logic sclk,
  output logic csN,
  output logic hostOe,
  output logic hostBit,
  // Link sense
  input wire logic dataOut,
  input wire logic bidirLine
);
  logic [7:0] rxByte;
  event rxEv;
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    hostOe = 1'b0;
    hostBit = 1'b0;
  end
  // Six core cycles a half gives the 48 ns link period
  task automatic halfWait();
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic start();
    @(posedge ref_clk);
    csN <= 1'b0;
    hostOe <= 1'b1;
    halfWait();
  endtask
  task automatic sendBits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      hostBit <= b[i];
      halfWait();
      sclk <= 1'b1;
      halfWait();
      sclk <= 1'b0;
    end
  endtask
  // Shared pin is let go before the fall that starts read data
  task automatic dummyByte(input logic [7:0] b);
    sendBits(b, 7);
    hostBit <= b[0];
    halfWait();
    sclk <= 1'b1;
    halfWait();
    hostOe <= 1'b0;
    @(posedge ref_clk);
    sclk <= 1'b0;
  endtask
  task automatic recv(input logic dual);
    logic [7:0] d;
    d = 8'h00;
    for (int k = 0; k < (dual ? 4 : 8); k++) begin
      halfWait();
      sclk <= 1'b1;
      d = dual ? {d[5:0], dataOut, bidirLine} : {d[6:0], dataOut};
      halfWait();
      sclk <= 1'b0;
    end
    rxByte = d;
    ->rxEv;
  endtask
  // Deselect with the clock parked low, half a period after the last fall
  task automatic stop();
    halfWait();
    csN <= 1'b1;
    hostOe <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

// File: dv/serial_flash_program_erase_test.sv
/* Bench of the flash sequencer: host model on the link, byte array
   model on the memory port. Assumes shortened program and erase counts. */
`timescale 1ns/10ps
module serial_flash_program_erase_test
  import sfpe_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce;
  logic topBottomSelect;
  logic [2:0] protectBits;
  logic [7:0] memRdData;
  logic ceQ = 1'b1;
  logic toggleQ = 1'b0;
  logic oeSeen = 1'b0;
  logic bothOe = 1'b0;
  logic sclk, csN, hostOe, hostBit, bidirLine;
  logic bidirDataPinOut, bidirDataPinOe, dataOut, dataOutOe;
  logic busy, writeEnableLatch, poweredDown;
  sfpe_mem_s memReq;
  logic [ADDR_W-1:0] memRdAddr;
  logic [7:0] mem [int];
  logic [7:0] expQ [$];
  logic [7:0] tx [$];
  logic [7:0] keep;
  int n_errors = 0;
  int num_checks = 0;
  int nWr = 0;
  int cyc = 0;
  int seed = 32'h700F;
  always #2 ref_clk = ~ref_clk;
  // Released line toggles so a stale bit can never look valid
  assign bidirLine = bidirDataPinOe ? bidirDataPinOut :
    hostOe ? hostBit : toggleQ;
  sfpe_host_model host (.ref_clk(ref_clk), .sclk(sclk), .csN(csN),
    .hostOe(hostOe), .hostBit(hostBit), .dataOut(dataOut),
    .bidirLine(bidirLine));
  sfpe_core #(.P_PAGE_WRITE_CYC(2000), .P_SECTOR_ERASE_CYC(40),
    .P_BLOCK_ERASE_CYC(50), .P_ARRAY_ERASE_CYC(60)) uut (.ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce), .sclk(sclk), .csN(csN), .bidirDataPinIn(bidirLine),
    .bidirDataPinOut(bidirDataPinOut), .bidirDataPinOe(bidirDataPinOe),
    .dataOut(dataOut), .dataOutOe(dataOutOe),
    .topBottomSelect(topBottomSelect), .protectBits(protectBits),
    .busy(busy), .writeEnableLatch(writeEnableLatch),
    .poweredDown(poweredDown), .memReq(memReq), .memRdAddr(memRdAddr),
    .memRdData(memRdData));
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  task automatic wipe(input sfpe_erase_e k, input int a);
    int keys [$];
    int sz;
    int lo;
    sz = (k == ER_SECTOR) ? 4096 : (k == ER_BLOCK) ? 65536 : 1 << ADDR_W;
    lo = a & ~(sz - 1);
    foreach (mem[i])
      if (i >= lo && i < lo + sz)
        keys.push_back(i);
    foreach (keys[j])
      mem.delete(keys[j]);
  endtask
  // Array model: programming only clears bits
  always @(posedge ref_clk) begin
    toggleQ <= ~toggleQ;
    // A request pulse stands while ce is low; take it only once
    ceQ <= ce;
    cyc++;
    memRdData <= rd(int'(memRdAddr));
    if (dataOutOe === 1'b1)
      oeSeen = 1'b1;
    if (bidirDataPinOe === 1'b1 && dataOutOe === 1'b1)
      bothOe = 1'b1;
    if (ceQ && memReq.wr === 1'b1) begin
      mem[int'(memReq.addr)] = rd(int'(memReq.addr)) & memReq.data;
      nWr++;
    end
    if (ceQ && memReq.erase === 1'b1)
      wipe(memReq.kind, int'(memReq.addr));
    if (cyc == 90000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(host.rxEv)
    check(host.rxByte, expQ.pop_front());
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, int n);
    host.start();
    host.sendBits(op, 8);
    for (int i = 0; i < n; i++)
      host.sendBits(a[23 - 8 * i -: 8], 8);
  endtask
  task automatic op1(input logic [7:0] op);
    cmd(op, 24'h000000, 0);
    host.stop();
  endtask
  task automatic erase(input logic [7:0] op, input logic [23:0] a);
    cmd(op, a, 3);
    host.stop();
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic status(input logic [7:0] exp);
    expQ.push_back(exp);
    cmd(OPC_RDSR, 24'h000000, 0);
    host.recv(1'b0);
    host.stop();
  endtask
  task automatic pageProg(input logic [23:0] a, input int n);
    tx.delete();
    cmd(OPC_PAGE, a, 3);
    for (int i = 0; i < n; i++) begin
      tx.push_back(8'($random(seed)));
      host.sendBits(tx[i], 8);
    end
    host.stop();
  endtask
  task automatic dualRead(input logic [23:0] a, input logic [7:0] e0, e1);
    expQ.push_back(e0);
    expQ.push_back(e1);
    expQ.push_back(8'hFF);
    expQ.push_back(8'hFF);
    cmd(OPC_DREAD, a, 3);
    host.dummyByte(8'($random(seed)));
    repeat (4) host.recv(1'b1);
    host.stop();
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    repeat (8) @(posedge ref_clk);
    // Random stalls: timers and the page walk must freeze, not skip
    while (busy !== 1'b0 && n < 4000) begin
      ce <= (($random(seed) & 3) != 0);
      @(posedge ref_clk);
      n++;
    end
    ce <= 1'b1;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    ce <= 1'b1;
    topBottomSelect <= 1'b0;
    protectBits <= BP_NONE;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check({poweredDown, writeEnableLatch, busy}, 16'h0);
    status(8'h00);
    pageProg(24'h000100, 2);
    waitIdle();
    check(16'(nWr), 16'h0);
    op1(OPC_WREN);
    status(8'h02);
    cmd(OPC_PAGE, 24'h000100, 3);
    host.sendBits(8'hAA, 8);
    host.sendBits(8'h55, 5);
    host.stop();
    repeat (20) @(posedge ref_clk);
    check({writeEnableLatch, busy, 14'(nWr)}, 16'h8000);
    pageProg(24'h000100, 258);
    check(busy, 16'h1);
    status(8'h03);
    op1(OPC_WRDI);
    status(8'h03);
    waitIdle();
    check({writeEnableLatch, busy}, 16'h0);
    check(16'(nWr), 16'h0100);
    for (int j = 0; j < 256; j++)
      check(rd(32'h100 + j), j < 2 ? tx[256 + j] : tx[j]);
    keep = tx[2];
    dualRead(24'h0001FE, tx[254], tx[255]);
    check(bothOe, 16'h1);
    op1(OPC_WREN);
    pageProg(24'h0002FE, 4);
    waitIdle();
    check({rd(32'h2FE), rd(32'h201)}, {tx[0], tx[3]});
    check({rd(32'h202), rd(32'h2FD)}, 16'hFFFF);
    protectBits <= BP_ALL;
    op1(OPC_WREN);
    pageProg(24'h000102, 1);
    op1(OPC_CHIP);
    erase(OPC_SECT, 24'h000100);
    waitIdle();
    check(rd(32'h102), keep);
    status(8'h1E);
    protectBits <= 3'h1;
    topBottomSelect <= 1'b1;
    erase(OPC_SECT, 24'h000105);
    check(busy, 16'h0);
    topBottomSelect <= 1'b0;
    erase(OPC_BLK, 24'h3F0000);
    check(busy, 16'h0);
    op1(OPC_CHIP);
    check(busy, 16'h0);
    pageProg(24'h00F000, 1);
    waitIdle();
    keep = tx[0];
    op1(OPC_WREN);
    erase(OPC_SECT, 24'h000105);
    waitIdle();
    check({rd(32'h102), rd(32'hF000)}, {8'hFF, keep});
    op1(OPC_WREN);
    erase(OPC_BLK, 24'h00ABCD);
    waitIdle();
    check(rd(32'hF000), 16'h00FF);
    protectBits <= BP_NONE;
    op1(OPC_WREN);
    pageProg(24'h3F0000, 1);
    waitIdle();
    check(16'(mem.num()), 16'h1);
    op1(OPC_WREN);
    op1(OPC_CHIP);
    waitIdle();
    check({writeEnableLatch, 15'(mem.num())}, 16'h0);
    op1(OPC_SLEEP);
    check(poweredDown, 16'h0);
    repeat (760) @(posedge ref_clk);
    check(poweredDown, 16'h1);
    oeSeen = 1'b0;
    cmd(OPC_RDSR, 24'h000000, 0);
    host.sendBits(8'h00, 8);
    host.stop();
    op1(OPC_WREN);
    check({oeSeen, writeEnableLatch}, 16'h0);
    op1(OPC_WAKE);
    check(poweredDown, 16'h0);
    status(8'h00);
    stop_test();
  end
endmodule
